/* rtl/cpu_core_regs.vh */
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// ****************************************
// APB byte offsets
// ****************************************
`define OFS_GPR_BASE 12'h000
`define OFS_SEG_BASE 12'h020
`define OFS_INSTR_PTR 12'h030
`define OFS_FLAGS 12'h034

// ****************************************
// General register indices
// ****************************************
`define GPR_ACC 3'h0
`define GPR_COUNT 3'h1
`define GPR_DATA 3'h2
`define GPR_BASE 3'h3
`define GPR_STACK_PTR 3'h4
`define GPR_BASE_PTR 3'h5
`define GPR_SRC_IDX 3'h6
`define GPR_DST_IDX 3'h7

// ****************************************
// Segment register indices
// ****************************************
`define SEG_EXTRA 2'h0
`define SEG_CODE 2'h1
`define SEG_STACK 2'h2
`define SEG_DATA 2'h3

// ****************************************
// Flag bit positions
// ****************************************
`define FLG_CARRY 0
`define FLG_PARITY 2
`define FLG_AUX 4
`define FLG_ZERO 6
`define FLG_SIGN 7
`define FLG_TRACE 8
`define FLG_IE 9
`define FLG_DIR 10
`define FLG_OVF 11
`define FLAGS_IMPL_MASK 16'h0fd5
`define FLAGS_RESET 16'h0000

// ****************************************
// Address generation
// ****************************************
`define SEG_SHIFT 4
`define IO_RSVD_LO 16'h00f8
`define IO_RSVD_HI 16'h00ff
`define RESET_WORD 16'h0000

`endif

/* rtl/cpu_register_set_addr_gen.v */
`include "cpu_core_regs.vh"

// What this block does
// RQ1: Eight 16-bit general registers; four also writable as independent byte halves.
// RQ2: Base word, base pointer, source and destination index feed operand offsets.
// RQ3: Stack accesses use stack pointer with stack segment; overrides are ignored.
// RQ4: Four segment registers select code, two data and stack segments.
// RQ5: Instruction pointer holds the offset of the next sequential instruction.
// RQ6: Flags word: status bits 0,2,4,6,7,11; control bits 8,9,10; rest reserved.
// RQ7: Overflow set when the signed result does not fit; cleared otherwise.
// RQ8: Direction flag set makes string steps decrement index registers, else increment.
// RQ9: Interrupt-enable flag gates maskable interrupts; clear blocks them.
// RQ10: Trace flag requests a trace interrupt; cleared after flags are pushed.
// RQ11: Sign flag equals the result's most significant bit.
// RQ12: Zero flag set when the result is zero.
// RQ13: Aux carry set on carry out of or borrow into the low nibble.
// RQ14: Parity flag set when the low result byte has even ones.
// RQ15: Carry flag set on carry or borrow at the most significant bit.
// RQ16: A flag marked undefined by an operation may take any value.
// RQ17: Physical address is segment shifted left four plus offset, 20 bits.
// RQ18: Every memory access pairs a segment register with a 16-bit offset.
// RQ19: I/O space is 64K byte ports or 32K word ports, apart from memory.
// RQ20: Port address from 8-bit immediate, zero-extended, or from data word.
// RQ21: Port addresses 00F8h to 00FFh are reserved and kept from user I/O; here they are still issued and only flagged on io_reserved_q.
// RQ22: Peripheral registers are reached through ordinary memory accesses.
// RQ23: Reserved flag bits read as zero and ignore writes.
module cpu_register_set_addr_gen (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // General register write from execution
    input wire gpr_wr,
    input wire gpr_wr_byte,
    input wire [2:0] gpr_wr_sel,
    input wire [15:0] gpr_wr_data,
    // General register read
    input wire [2:0] gpr_rd_sel,
    input wire gpr_rd_byte,
    output reg [15:0] gpr_rd_data_q,
    // Segment write
    input wire seg_wr,
    input wire [1:0] seg_wr_sel,
    input wire [15:0] seg_wr_data,
    // Instruction pointer
    input wire iptr_load,
    input wire [15:0] iptr_load_data,
    input wire iptr_advance,
    input wire [3:0] iptr_advance_len,
    output reg [15:0] instruction_pointer_q,
    output reg [19:0] fetch_addr_q,
    // Arithmetic flag update
    input wire alu_update,
    input wire alu_byte,
    input wire alu_sub,
    input wire alu_cin,
    input wire [15:0] alu_a,
    input wire [15:0] alu_b,
    input wire [5:0] alu_keep,
    input wire [5:0] alu_undef,
    output reg [15:0] alu_result_q,
    // Flag control
    input wire flags_load,
    input wire [15:0] flags_load_data,
    input wire set_dir,
    input wire clr_dir,
    input wire set_ie,
    input wire clr_ie,
    input wire trace_ack,
    output reg [15:0] processor_status_flags_q,
    // Interrupt gating
    input wire maskable_irq,
    output reg irq_take_q,
    output reg trace_req_q,
    // Memory address generation
    input wire agen_req,
    input wire agen_stack,
    input wire agen_ovr,
    input wire [1:0] agen_seg_sel,
    input wire [1:0] agen_base_sel,
    input wire [1:0] agen_idx_sel,
    input wire [15:0] agen_disp,
    output reg agen_valid_q,
    output reg [15:0] agen_offset_q,
    output reg [19:0] phys_addr_q,
    // String index stepping
    input wire str_step_src,
    input wire str_step_dst,
    input wire str_word,
    // I/O addressing
    input wire io_req,
    input wire io_imm,
    input wire io_word,
    input wire [7:0] io_port_imm,
    output reg io_valid_q,
    output reg io_word_q,
    output reg [15:0] io_addr_q,
    output reg io_reserved_q
);

    // ****************************************
    // State
    // ****************************************
    reg [15:0] gpr_q [0:7];
    reg [15:0] seg_q [0:3];
    integer i;

    // ****************************************
    // APB decode
    // ****************************************
    wire apb_acc = psel & penable & ~pready;
    wire apb_done = psel & penable & pready;
    wire hit_gpr = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'b00);
    wire hit_seg = (paddr[11:4] == 8'h02) & (paddr[1:0] == 2'b00);
    wire hit_iptr = (paddr == `OFS_INSTR_PTR);
    wire hit_flags = (paddr == `OFS_FLAGS);
    wire hit_any = hit_gpr | hit_seg | hit_iptr | hit_flags;
    reg [15:0] apb_rd;

    always @*
    begin
        apb_rd = 16'h0000;
        if (hit_gpr)
            apb_rd = gpr_q[paddr[4:2]];
        else if (hit_seg)
            apb_rd = seg_q[paddr[3:2]];
        else if (hit_iptr)
            apb_rd = instruction_pointer_q;
        else if (hit_flags)
            apb_rd = processor_status_flags_q;
    end

    // ****************************************
    // Flag computation
    // ****************************************
    // Byte operands are masked so bit 8 is the carry or borrow of the byte
    wire [15:0] op_a = alu_byte ? {8'h00, alu_a[7:0]} : alu_a;
    wire [15:0] op_b = alu_byte ? {8'h00, alu_b[7:0]} : alu_b;
    wire [16:0] sum = alu_sub ? ({1'b0, op_a} - {1'b0, op_b} - {16'h0000, alu_cin})
                              : ({1'b0, op_a} + {1'b0, op_b} + {16'h0000, alu_cin});
    wire [15:0] res = alu_byte ? {8'h00, sum[7:0]} : sum[15:0];
    wire msb_a = alu_byte ? op_a[7] : op_a[15];
    wire msb_b = alu_byte ? op_b[7] : op_b[15];
    wire msb_r = alu_byte ? res[7] : res[15];
    wire f_carry = alu_byte ? sum[8] : sum[16]; // RQ15
    wire f_aux = op_a[4] ^ op_b[4] ^ sum[4]; // RQ13
    wire f_ovf = alu_sub ? ((msb_a != msb_b) & (msb_r != msb_a))
                         : ((msb_a == msb_b) & (msb_r != msb_a)); // RQ7
    wire f_sign = msb_r; // RQ11
    wire f_zero = (res == 16'h0000); // RQ12
    wire f_par = ~^res[7:0]; // RQ14
    // Order: carry, parity, aux, zero, sign, overflow
    wire [5:0] f_new = {f_ovf, f_sign, f_zero, f_aux, f_par, f_carry};
    // Undefined flags are forced to zero; software must not rely on them
    wire [5:0] f_use = f_new & ~alu_undef; // RQ16
    reg [15:0] flags_d;

    always @*
    begin
        flags_d = processor_status_flags_q;
        if (flags_load)
            flags_d = flags_load_data;
        if (alu_update)
        begin
            if (!alu_keep[0])
                flags_d[`FLG_CARRY] = f_use[0];
            if (!alu_keep[1])
                flags_d[`FLG_PARITY] = f_use[1];
            if (!alu_keep[2])
                flags_d[`FLG_AUX] = f_use[2];
            if (!alu_keep[3])
                flags_d[`FLG_ZERO] = f_use[3];
            if (!alu_keep[4])
                flags_d[`FLG_SIGN] = f_use[4];
            if (!alu_keep[5])
                flags_d[`FLG_OVF] = f_use[5];
        end
        if (set_dir)
            flags_d[`FLG_DIR] = 1'b1;
        if (clr_dir)
            flags_d[`FLG_DIR] = 1'b0;
        if (set_ie)
            flags_d[`FLG_IE] = 1'b1;
        if (clr_ie)
            flags_d[`FLG_IE] = 1'b0;
        // The flags word has already been pushed when the ack arrives
        if (trace_ack)
            flags_d[`FLG_TRACE] = 1'b0; // RQ10
        flags_d = flags_d & `FLAGS_IMPL_MASK; // RQ6 RQ23
    end

    // ****************************************
    // Address generation
    // ****************************************
    reg [15:0] base_v;
    reg [15:0] idx_v;
    reg [1:0] seg_v;
    wire [15:0] mem_ofs = agen_stack ? gpr_q[`GPR_STACK_PTR] : (base_v + idx_v + agen_disp); // RQ3

    always @*
    begin
        case (agen_base_sel) // RQ2
            2'h1: base_v = gpr_q[`GPR_BASE];
            2'h2: base_v = gpr_q[`GPR_BASE_PTR];
            default: base_v = 16'h0000;
        endcase
        case (agen_idx_sel) // RQ2
            2'h1: idx_v = gpr_q[`GPR_SRC_IDX];
            2'h2: idx_v = gpr_q[`GPR_DST_IDX];
            default: idx_v = 16'h0000;
        endcase
        // Bare base pointer addressing defaults to the stack segment
        if (agen_stack)
            seg_v = `SEG_STACK; // RQ3
        else if (agen_ovr)
            seg_v = agen_seg_sel;
        else if (agen_base_sel == 2'h2)
            seg_v = `SEG_STACK;
        else
            seg_v = `SEG_DATA;
    end

    // String step: direction flag selects the sign, width the size
    wire [15:0] step = str_word ? 16'h0002 : 16'h0001;
    wire [15:0] src_next = processor_status_flags_q[`FLG_DIR] ?
        (gpr_q[`GPR_SRC_IDX] - step) : (gpr_q[`GPR_SRC_IDX] + step); // RQ8
    wire [15:0] dst_next = processor_status_flags_q[`FLG_DIR] ?
        (gpr_q[`GPR_DST_IDX] - step) : (gpr_q[`GPR_DST_IDX] + step); // RQ8
    wire [15:0] iptr_next = iptr_load ? iptr_load_data :
        (instruction_pointer_q + {12'h000, iptr_advance_len});
    wire [15:0] io_port = io_imm ? {8'h00, io_port_imm} : gpr_q[`GPR_DATA]; // RQ20

    // ****************************************
    // Register file update
    // ****************************************
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            for (i = 0; i < 8; i = i + 1)
                gpr_q[i] <= `RESET_WORD;
            for (i = 0; i < 4; i = i + 1)
                seg_q[i] <= `RESET_WORD;
            instruction_pointer_q <= `RESET_WORD;
            processor_status_flags_q <= `FLAGS_RESET;
        end
        else
        begin
            // Software writes first so the execution side wins a collision, except on the flags word, where the APB write wins
            if (apb_done & pwrite & hit_gpr)
                gpr_q[paddr[4:2]] <= pwdata[15:0];
            if (apb_done & pwrite & hit_seg)
                seg_q[paddr[3:2]] <= pwdata[15:0];
            if (str_step_src)
                gpr_q[`GPR_SRC_IDX] <= src_next;
            if (str_step_dst)
                gpr_q[`GPR_DST_IDX] <= dst_next;
            if (gpr_wr)
            begin
                if (!gpr_wr_byte)
                    gpr_q[gpr_wr_sel] <= gpr_wr_data; // RQ1
                else if (gpr_wr_sel[2])
                    gpr_q[{1'b0, gpr_wr_sel[1:0]}][15:8] <= gpr_wr_data[7:0]; // RQ1
                else
                    gpr_q[{1'b0, gpr_wr_sel[1:0]}][7:0] <= gpr_wr_data[7:0]; // RQ1
            end
            if (seg_wr)
                seg_q[seg_wr_sel] <= seg_wr_data; // RQ4
            if (apb_done & pwrite & hit_iptr)
                instruction_pointer_q <= pwdata[15:0];
            if (iptr_load | iptr_advance)
                instruction_pointer_q <= iptr_next; // RQ5
            if (apb_done & pwrite & hit_flags)
                processor_status_flags_q <= pwdata[15:0] & `FLAGS_IMPL_MASK; // RQ23
            else
                processor_status_flags_q <= flags_d;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            gpr_rd_data_q <= 16'h0000;
            fetch_addr_q <= 20'h00000;
            alu_result_q <= 16'h0000;
            irq_take_q <= 1'b0;
            trace_req_q <= 1'b0;
            agen_valid_q <= 1'b0;
            agen_offset_q <= 16'h0000;
            phys_addr_q <= 20'h00000;
            io_valid_q <= 1'b0;
            io_word_q <= 1'b0;
            io_addr_q <= 16'h0000;
            io_reserved_q <= 1'b0;
        end
        else
        begin
            // One wait state keeps read data straight from a flip-flop
            pready <= apb_acc;
            pslverr <= apb_acc & ~hit_any;
            if (apb_acc)
                prdata <= {16'h0000, apb_rd};
            if (!gpr_rd_byte)
                gpr_rd_data_q <= gpr_q[gpr_rd_sel];
            else if (gpr_rd_sel[2])
                gpr_rd_data_q <= {8'h00, gpr_q[{1'b0, gpr_rd_sel[1:0]}][15:8]}; // RQ1
            else
                gpr_rd_data_q <= {8'h00, gpr_q[{1'b0, gpr_rd_sel[1:0]}][7:0]}; // RQ1
            fetch_addr_q <= {seg_q[`SEG_CODE], 4'h0} + {4'h0, instruction_pointer_q}; // RQ17
            if (alu_update)
                alu_result_q <= res;
            irq_take_q <= maskable_irq & processor_status_flags_q[`FLG_IE]; // RQ9
            trace_req_q <= processor_status_flags_q[`FLG_TRACE]; // RQ10
            // Peripheral registers are plain memory targets here
            agen_valid_q <= agen_req; // RQ22
            if (agen_req)
            begin
                agen_offset_q <= mem_ofs; // RQ18
                phys_addr_q <= {seg_q[seg_v], 4'h0} + {4'h0, mem_ofs}; // RQ17 RQ18
            end
            io_valid_q <= io_req; // RQ19
            if (io_req)
            begin
                io_word_q <= io_word; // RQ19
                io_addr_q <= io_port; // RQ20
                io_reserved_q <= (io_port >= `IO_RSVD_LO) & (io_port <= `IO_RSVD_HI); // RQ21
            end
        end
    end

endmodule

/* tb/regs_asserts.sv */
module regs_asserts (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // APB
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Flags
    input wire alu_update,
    input wire [5:0] alu_keep,
    input wire [5:0] alu_undef,
    input wire flags_load,
    input wire [15:0] alu_result_q,
    input wire [15:0] processor_status_flags_q,
    input wire maskable_irq,
    input wire irq_take_q,
    // Addressing
    input wire agen_req,
    input wire agen_valid_q,
    input wire io_req,
    input wire io_imm,
    input wire [7:0] io_port_imm,
    input wire io_valid_q,
    input wire [15:0] io_addr_q,
    input wire io_reserved_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // ****************************************
    // Properties
    // ****************************************
    property p_ready;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error answer wrong");
    property p_rsvd;
        (processor_status_flags_q & 16'hf02a) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag bit set");
    property p_agen;
        agen_req |=> agen_valid_q;
    endproperty
    a_agen: assert property (p_agen) else $error("address not valid");
    property p_io_ext;
        io_req && io_imm |=> io_valid_q && io_addr_q == {8'h00, $past(io_port_imm)};
    endproperty
    a_io_ext: assert property (p_io_ext) else $error("port not zero-extended");
    property p_io_rsvd;
        io_valid_q |-> io_reserved_q == (io_addr_q >= 16'h00f8 && io_addr_q <= 16'h00ff);
    endproperty
    a_io_rsvd: assert property (p_io_rsvd) else $error("reserved port wrong");
    property p_irq;
        1'b1 |=> irq_take_q == $past(maskable_irq && processor_status_flags_q[9]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt gating wrong");
    sequence s_plain;
        alu_update && !flags_load && !psel && alu_keep == 6'h00 && alu_undef == 6'h00;
    endsequence
    property p_zero;
        s_plain |=> processor_status_flags_q[6] == (alu_result_q == 16'h0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_parity;
        s_plain |=> processor_status_flags_q[2] == ~^alu_result_q[7:0];
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    c_agen: cover property (agen_valid_q);
    c_io_rsvd: cover property (io_valid_q && io_reserved_q);
    c_err: cover property (pready && pslverr);
    c_irq: cover property (irq_take_q);
endmodule
bind cpu_register_set_addr_gen regs_asserts i_chk (.clock, .rstn, .psel, .penable, .prdata,
    .pready, .pslverr, .alu_update, .alu_keep, .alu_undef, .flags_load, .alu_result_q,
    .processor_status_flags_q, .maskable_irq, .irq_take_q, .agen_req, .agen_valid_q, .io_req,
    .io_imm, .io_port_imm, .io_valid_q, .io_addr_q, .io_reserved_q);

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, gpr_wr = 0, gpr_wr_byte = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, d;
    wire [31:0] prdata;
    wire pready, pslverr, trace_ack, irq_take_q, trace_req_q, agen_valid_q, io_valid_q;
    wire io_word_q, io_reserved_q;
    logic [2:0] gpr_wr_sel = '0, gpr_rd_sel = '0;
    logic [1:0] seg_wr_sel = '0, agen_seg_sel = '0, agen_base_sel = '0, agen_idx_sel = '0;
    logic [15:0] gpr_wr_data = '0, seg_wr_data = '0, iptr_load_data = '0, alu_a = '0, alu_b = '0;
    logic [15:0] flags_load_data = '0, agen_disp = '0, s = 16'h0028, r, ef, fl, va, vb;
    wire [15:0] gpr_rd_data_q, instruction_pointer_q, alu_result_q, processor_status_flags_q;
    wire [15:0] agen_offset_q, io_addr_q;
    wire [19:0] fetch_addr_q, phys_addr_q;
    logic [3:0] iptr_advance_len = '0;
    logic [5:0] alu_keep = '0, alu_undef = '0;
    logic [7:0] io_port_imm = '0;
    logic [16:0] sum;
    logic seg_wr = 0, iptr_load = 0, iptr_advance = 0, alu_update = 0, alu_byte = 0, alu_sub = 0;
    logic alu_cin = 0, flags_load = 0, set_dir = 0, clr_dir = 0, set_ie = 0, clr_ie = 0, e;
    logic maskable_irq = 0, agen_req = 0, agen_stack = 0, agen_ovr = 0, str_step_src = 0;
    logic str_step_dst = 0, str_word = 0, io_req = 0, io_imm = 0, io_word = 0, gpr_rd_byte = 0;
    int n_mismatch = 0, check_count = 0, cycles = 0, gpr[8], seg[4], m;
    cpu_register_set_addr_gen i_dut (.*);
    trace_partner i_partner (.clock, .rstn, .trace_req(trace_req_q), .delay(4'h3), .trace_ack);
    initial
    begin
        forever #50 clock = ~clock;
    end
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic finish_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(what, x, d);
    endtask
    task automatic edge_clr;
        @(posedge clock);
        {gpr_wr, seg_wr, iptr_load, iptr_advance, alu_update, flags_load, io_req} <= '0;
        {set_dir, clr_dir, set_ie, clr_ie, agen_req, str_step_src, str_step_dst} <= '0;
    endtask
    task automatic wr_gpr(input logic b, input logic [2:0] i, input logic [15:0] v);
        @(posedge clock);
        {gpr_wr, gpr_wr_byte, gpr_wr_sel, gpr_wr_data} <= {1'b1, b, i, v};
        if (!b)
            gpr[i] = v;
        else if (i < 4)
            gpr[i] = (gpr[i] & 'hff00) | v[7:0];
        else
            gpr[i - 4] = (gpr[i - 4] & 'h00ff) | (v[7:0] << 8);
        edge_clr;
    endtask
    task automatic wr_seg(input logic [1:0] i, input logic [15:0] v);
        @(posedge clock);
        {seg_wr, seg_wr_sel, seg_wr_data} <= {1'b1, i, v};
        seg[i] = v;
        edge_clr;
    endtask
    task automatic agen(input logic st, input logic [15:0] dp, input logic [19:0] x);
        @(posedge clock);
        {agen_req, agen_seg_sel, agen_base_sel} <= {1'b1, 2'h3, 2'h1};
        {agen_idx_sel, agen_disp, agen_stack, agen_ovr} <= {st ? 2'h0 : 2'h2, dp, st, st};
        edge_clr;
        #1;
        chk("phys", x, phys_addr_q);
        chk("agen_offset", st ? gpr[4] : (dp + gpr[3] + gpr[7]) & 'hffff, agen_offset_q);
    endtask
    task automatic io(input logic im, input logic [7:0] p, input logic [15:0] x);
        @(posedge clock);
        {io_req, io_imm, io_word, io_port_imm} <= {1'b1, im, !im, p};
        edge_clr;
        #1;
        chk("io_addr", x, io_addr_q);
        chk("io_word", !im, io_word_q);
        chk("io_rsvd", x >= 16'h00f8 && x <= 16'h00ff, io_reserved_q);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            finish_test;
        end
    end
    initial
    begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rd_chk("flags", 12'h034, 32'h0);
        apb(1'b1, 12'h034, 32'h0000_f02a);
        rd_chk("flags", 12'h034, 32'h0);
        apb(1'b1, 12'h034, 32'h0000_0ed5);
        rd_chk("flags", 12'h034, 32'h0000_0ed5);
        apb(1'b1, 12'h034, 32'h0);
        rd_chk("unmapped", 12'h0ff0, 32'h0);
        chk("slverr", 1'b1, e);
        wr_gpr(1'b1, 3'h0, 16'h0034);
        wr_gpr(1'b1, 3'h4, 16'h0012);
        rd_chk("acc", 12'h000, gpr[0]);
        {gpr_rd_sel, gpr_rd_byte} <= 4'b1001;
        @(posedge clock);
        #1;
        chk("gpr_rd", gpr[0] >> 8, gpr_rd_data_q);
        wr_seg(2'h3, 16'h12a4);
        agen(1'b0, 16'h0022, 20'h12a62);
        s = lfsr(s);
        wr_seg(2'h2, s);
        s = lfsr(s);
        wr_gpr(1'b0, 3'h4, s);
        agen(1'b1, 16'h0000, ((seg[2] << 4) + gpr[4]) & 'hfffff);
        wr_gpr(1'b0, 3'h6, 16'h0010);
        @(posedge clock);
        set_dir <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            {set_dir, str_step_src, str_step_dst, str_word} <= {3'b011, i == 0};
            edge_clr;
        end
        rd_chk("src_idx", 12'h018, 32'h000d);
        rd_chk("dst_idx", 12'h01c, 32'hfffd);
        @(posedge clock);
        clr_dir <= 1'b1;
        edge_clr;
        @(posedge clock);
        {str_step_src, str_step_dst, str_word} <= 3'b111;
        edge_clr;
        rd_chk("src_idx", 12'h018, 32'h000f);
        wr_seg(2'h1, 16'hf00f);
        @(posedge clock);
        {iptr_load, iptr_load_data} <= {1'b1, 16'h0100};
        edge_clr;
        @(posedge clock);
        {iptr_advance, iptr_advance_len} <= {1'b1, 4'h3};
        edge_clr;
        rd_chk("iptr", 12'h030, 32'h0103);
        #1;
        chk("iptr_q", 32'h0103, instruction_pointer_q);
        chk("fetch", 32'h000f01f3, fetch_addr_q);
        io(1'b1, 8'hfa, 16'h00fa);
        wr_gpr(1'b0, 3'h2, 16'habcd);
        io(1'b0, 8'hf8, 16'habcd);
        @(posedge clock);
        {set_ie, maskable_irq} <= 2'b11;
        edge_clr;
        @(posedge clock);
        #1;
        chk("irq_take", 1'b1, irq_take_q);
        @(posedge clock);
        clr_ie <= 1'b1;
        edge_clr;
        @(posedge clock);
        #1;
        chk("irq_take", 1'b0, irq_take_q);
        @(posedge clock);
        {flags_load, flags_load_data} <= {1'b1, 16'h0100};
        edge_clr;
        #1;
        chk("trace_set", 16'h0100, processor_status_flags_q);
        @(posedge clock);
        #1;
        chk("trace_req", 1'b1, trace_req_q);
        repeat (12) @(posedge clock);
        #1;
        chk("trace_clr", 16'h0000, processor_status_flags_q);
        fl = 16'h0000;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clock);
            s = lfsr(s);
            m = s[2] ? 7 : 15;
            va = s & (s[2] ? 16'h00ff : 16'hffff);
            vb = lfsr(s) & (s[2] ? 16'h00ff : 16'hffff);
            alu_a <= s;
            {alu_byte, alu_sub} <= s[2:1];
            sum = s[1] ? va - vb - s[0] : va + vb + s[0];
            r = sum[15:0] & (s[2] ? 16'h00ff : 16'hffff);
            ef = fl;
            ef[0] = (i == 1) ? fl[0] : sum[m + 1];
            ef[2] = ~^r[7:0];
            ef[4] = s[1] ? s[3:0] < {1'b0, vb[3:0]} + s[0] : s[3:0] + vb[3:0] + s[0] > 15;
            ef[6] = r == 16'h0000;
            ef[7] = r[m];
            ef[11] = (i != 2) && (s[1] ? s[m] != vb[m] : s[m] == vb[m]) && (r[m] != s[m]);
            {alu_b, alu_cin, alu_keep, alu_undef} <= {lfsr(s), s[0], 5'h0, i == 1, i == 2, 5'h0};
            alu_update <= 1'b1;
            edge_clr;
            #1;
            chk("alu_result", r, alu_result_q);
            chk("alu_flags", ef, processor_status_flags_q);
            fl = ef;
        end
        finish_test;
    end
endmodule

/* tb/trace_partner.sv */
module trace_partner (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Trace handshake
    input wire trace_req,
    input wire [3:0] delay,
    output logic trace_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // The flags push takes delay plus one cycles; only then is the trace flag released
    always @(posedge clock)
    begin
        trace_ack <= 1'b0;
        if (!rstn || !trace_req || trace_ack)
            cnt <= 0;
        else if (cnt == delay)
            trace_ack <= 1'b1;
        else
            cnt <= cnt + 1;
    end
endmodule
